/* File: hdl/packet_format_config.sv */
// Purpose : frame-format configuration registers for the packet framer
// Assumes : AHB-Lite slave, zero wait states, word accesses only
// Notes   : framer pulses opStart/opDone; settings are snapshotted at start
`timescale 1ns/10ps
module packet_format_config
    import pkt_fmt_pkg::*;
(
    input  wire logic        mclk,        // system clock
    input  wire logic        rstn,        // async reset, active low
    input  wire logic        hsel,        // slave select
    input  wire logic [31:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic [2:0]  hsize,       // transfer size
    input  wire logic [31:0] hwdata,      // write data
    input  wire logic        hready,      // bus ready
    input  wire logic        opStart,     // tx or rx operation begins
    input  wire logic        opDone,      // operation finished
    output logic      [31:0] hrdata,      // read data
    output logic             hreadyout,   // slave ready
    output logic             hresp,       // response
    output cfg_t             frameCfg,    // snapshot used by the framer
    output logic             opActive,    // operation in progress
    output logic             cfgPending   // decoded register settings differ from snapshot
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // byte mask of writable bits per slot
    function automatic logic [7:0] slot_mask(input logic [2:0] slot);
        logic [7:0] m;
        m = MASK_FULL;
        // reserved bits never take a write
        if (slot == 3'(IDX_LEN_ADDR - IDX_SYNC_PRE)) begin
            m = MASK_LEN_ADDR;
        end else if (slot == 3'(IDX_CODING - IDX_SYNC_PRE)) begin
            m = MASK_CODING;
        end
        return m;
    endfunction : slot_mask

    // polynomial for a crc selector
    // selectors 6 and 7 give no crc field
    function automatic logic [31:0] crc_poly(input logic [2:0] sel);
        logic [31:0] p;
        p = POLY_NONE;
        case (sel)
            3'd1: p = POLY_1;
            3'd2: p = POLY_2;
            3'd3: p = POLY_3;
            3'd4: p = POLY_4;
            3'd5: p = POLY_5;
            default: p = POLY_NONE;  // none or unused selector
        endcase
        return p;
    endfunction : crc_poly

    // crc width for a crc selector
    function automatic logic [5:0] crc_width(input logic [2:0] sel);
        logic [5:0] w;
        w = CRCW_0;
        case (sel)
            3'd1: w = CRCW_8;
            3'd2: w = CRCW_16;
            3'd3: w = CRCW_16;
            3'd4: w = CRCW_24;
            3'd5: w = CRCW_32;
            default: w = CRCW_0;
        endcase
        return w;
    endfunction : crc_width

    // turn the six register bytes into the framer view
    function automatic cfg_t decode_cfg(
        input logic [7:0] r6,
        input logic [7:0] r5,
        input logic [7:0] r4,
        input logic [7:0] r3,
        input logic [7:0] r2,
        input logic [7:0] r1
    );
        cfg_t c;
        logic isG4;
        logic isUart;
        c = '0;
        c.syncLenBits     = r6[POS_SYNC_HI:POS_SYNC_LO];
        c.preamblePairs   = {r6[POS_PREH_HI:POS_PREH_LO], r5};
        c.lenTwoBytes     = r4[POS_LEN_WIDTH];
        c.addrInclude     = r4[POS_ADDR_INC];
        c.frameFormat     = frame_fmt_t'(r3[POS_FMT_HI:POS_FMT_LO]);
        c.rxPath          = r3[POS_RXP_HI:POS_RXP_LO];
        c.symMapAlt       = r3[POS_SYMMAP];
        c.lsbFirst        = r3[POS_BITORD];
        c.preamblePattern = r3[POS_PPAT_HI:POS_PPAT_LO];
        isG4   = (c.frameFormat == FMT_G4);
        isUart = (c.frameFormat == FMT_UART);
        c.headerCheck     = isG4 & r2[POS_HDRCHK];
        c.fecRecursive    = isG4 & r2[POS_FEC_STOP];
        c.interleave      = isG4 & r2[POS_INT_START];
        c.stopValue       = isUart & r2[POS_FEC_STOP];
        c.startValue      = isUart & r2[POS_INT_START];
        c.threeOfSix      = r2[POS_3OF6];
        c.biphase         = r2[POS_BIPHASE];
        c.lengthVariable  = r2[POS_LENMODE];
        c.crcSel          = r1[POS_CRC_HI:POS_CRC_LO];
        c.crcPoly         = crc_poly(c.crcSel);
        c.crcWidth        = crc_width(c.crcSel);
        return c;
    endfunction : decode_cfg

    // snapshot value after reset
    localparam cfg_t CFG_RESET = decode_cfg(RST_SYNC_PRE, RST_PRE_LO, RST_LEN_ADDR,
                                            RST_FMT_RX, RST_CODING, RST_CRC);

    // ------------------------------------------------------------------
    // operation state
    // ------------------------------------------------------------------
    // two states one bit apart, so every step is a gray step
    typedef enum logic [1:0] {
        OP_IDLE   = 2'b00,  // no frame in flight
        OP_ACTIVE = 2'b01   // frame in flight, settings frozen
    } op_state_t;

    op_state_t   state_reg;        // current state
    op_state_t   state_next;       // next state

    // ------------------------------------------------------------------
    // storage and bus tracking
    // ------------------------------------------------------------------
    logic [7:0]  cfgRegs_reg [NUM_CFG];  // configuration bytes
    logic        wrPend_reg;       // write data phase follows
    logic        wrValid_reg;      // pending write hits a config slot
    logic [2:0]  wrSlot_reg;       // slot of pending write
    logic [31:0] hrdata_reg;       // read data flop
    logic        hreadyout_reg;    // ready flop
    cfg_t        frameCfg_reg;     // frozen settings
    logic        cfgPending_reg;   // difference flag
    logic        opActive_reg;     // operation flag flop
    logic        hresp_reg;        // response flop

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // address phase decode, taken only while the bus is ready
    wire logic        addrPhase = hsel & hready & (htrans[1] == HTRANS_NONSEQ[1]);
    wire logic [7:0]  reqIdx    = haddr[9:2];                // word index
    wire logic        idxHigh   = (haddr[31:10] != 22'h00_0000);
    wire logic        reqIsCfg  = !idxHigh && (reqIdx >= IDX_SYNC_PRE)
                                  && (reqIdx <= IDX_CRC);
    wire logic        reqIsStat = !idxHigh && (reqIdx == IDX_STATUS);
    wire logic [7:0]  reqOff    = reqIdx - IDX_SYNC_PRE;
    wire logic [2:0]  reqSlot   = reqOff[2:0];
    wire logic        rdReq     = addrPhase & !hwrite;
    wire logic        wrReq     = addrPhase & hwrite;

    // write data phase
    // the byte is stored at the end of the data phase
    wire logic        wrDo      = wrPend_reg & wrValid_reg;
    wire logic [7:0]  wrByte    = hwdata[7:0] & slot_mask(wrSlot_reg);

    // ------------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------------
    // live decode of the register contents
    // feeds both the snapshot and the pending compare
    wire cfg_t        liveCfg   = decode_cfg(cfgRegs_reg[0], cfgRegs_reg[1],
                                             cfgRegs_reg[2], cfgRegs_reg[3],
                                             cfgRegs_reg[4], cfgRegs_reg[5]);

    // read mux, forwarding a write landing this edge
    // without it a read right behind a write to the same slot
    // would return the old byte, since both use the same edge
    wire logic        fwdHit    = wrDo && (wrSlot_reg == reqSlot);
    wire logic [7:0]  cfgByte   = fwdHit ? wrByte : cfgRegs_reg[reqSlot];
    wire logic [31:0] statWord  = {30'h0000_0000, cfgPending_reg, opActive};
    wire logic [31:0] rdWord;

    // ------------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------------
    // unused bits as zero
    assign rdWord = reqIsCfg  ? {24'h00_0000, cfgByte} :
                    reqIsStat ? statWord :
                                32'h0000_0000;   // unmapped reads zero

    // ------------------------------------------------------------------
    // bus slave flops
    // ------------------------------------------------------------------

    // capture write address phase
    // slot index only counts while wrValid is set
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg  <= 1'b0;
            wrValid_reg <= 1'b0;
            wrSlot_reg  <= 3'h0;
        end else if (hready) begin
            wrPend_reg  <= wrReq;
            wrValid_reg <= wrReq & reqIsCfg;   // status and unmapped ignored
            wrSlot_reg  <= reqSlot;
        end
    end

    // read data for the next data phase
    // loaded only by a read address phase, held otherwise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rdReq) begin
            hrdata_reg <= rdWord;
        end
    end

    // zero wait states, always ready
    // the bus never stalls on this slave
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hreadyout_reg <= 1'b1;
        end else begin
            hreadyout_reg <= 1'b1;
        end
    end

    // no error response, reserved and unmapped accesses included
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hresp_reg <= HRESP_OKAY;
        end else begin
            hresp_reg <= HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------------

    // one byte lane is stored, the upper lanes are dropped
    // masked register write
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfgRegs_reg[0] <= RST_SYNC_PRE;
            cfgRegs_reg[1] <= RST_PRE_LO;
            cfgRegs_reg[2] <= RST_LEN_ADDR;
            cfgRegs_reg[3] <= RST_FMT_RX;
            cfgRegs_reg[4] <= RST_CODING;
            cfgRegs_reg[5] <= RST_CRC;
        end else if (wrDo) begin
            cfgRegs_reg[wrSlot_reg] <= wrByte;
        end
    end

    // ------------------------------------------------------------------
    // operation tracking
    // ------------------------------------------------------------------

    // start wins over done
    // a start in the same cycle as a done keeps the frame open
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OP_IDLE: begin
                if (opStart) begin
                    state_next = OP_ACTIVE;
                end
            end
            OP_ACTIVE: begin
                if (opDone && !opStart) begin
                    state_next = OP_IDLE;
                end
            end
            default: state_next = OP_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= OP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // operation flag in its own flop, same timing as the state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            opActive_reg <= 1'b0;
        end else begin
            opActive_reg <= (state_next == OP_ACTIVE);
        end
    end

    // a write landing on the start edge is not seen:
    // the snapshot takes the contents from before that edge
    // freeze at operation start
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            frameCfg_reg <= CFG_RESET;
        end else if (opStart) begin
            frameCfg_reg <= liveCfg;
        end
    end

    // flags a change waiting for next start
    // one cycle behind the registers, a status hint only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfgPending_reg <= 1'b0;
        end else begin
            cfgPending_reg <= (liveCfg != frameCfg_reg);
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hrdata     = hrdata_reg;
    assign hreadyout  = hreadyout_reg;
    assign hresp      = hresp_reg;
    assign frameCfg   = frameCfg_reg;
    assign opActive   = opActive_reg;
    assign cfgPending = cfgPending_reg;

    // size is not checked; byte lanes other than 7:0 are dropped
    wire logic unusedSize = ^hsize;

endmodule : packet_format_config

/* File: hdl/pkt_fmt_pkg.sv */
// Purpose : shared constants and types for the frame-format register block
// Assumes : one 25 MHz clock, AHB-Lite register access, one word per register
// Notes   : register indices are word indices, byte address is four times the index
package pkt_fmt_pkg;

    // ------------------------------------------------------------------
    // register indices and bus constants
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_SYNC_PRE   = 8'h2B;  // sync length, preamble high
    localparam logic [7:0]  IDX_PRE_LO     = 8'h2C;  // preamble low byte
    localparam logic [7:0]  IDX_LEN_ADDR   = 8'h2D;  // length width, address field
    localparam logic [7:0]  IDX_FMT_RX     = 8'h2E;  // format, rx path, ordering
    localparam logic [7:0]  IDX_CODING     = 8'h2F;  // coding options
    localparam logic [7:0]  IDX_CRC        = 8'h30;  // crc select
    localparam logic [7:0]  IDX_STATUS     = 8'h3F;  // framer status, read only
    localparam int          NUM_CFG        = 6;      // configuration registers
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;  // transfer type bit 1
    localparam logic        HRESP_OKAY     = 1'b0;   // only response used

    // ------------------------------------------------------------------
    // reset values and writable bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_SYNC_PRE   = 8'h80;
    localparam logic [7:0]  RST_PRE_LO     = 8'h10;
    localparam logic [7:0]  RST_LEN_ADDR   = 8'h00;
    localparam logic [7:0]  RST_FMT_RX     = 8'h20;
    localparam logic [7:0]  RST_CODING     = 8'h00;
    localparam logic [7:0]  RST_CRC        = 8'h2C;
    localparam logic [7:0]  MASK_LEN_ADDR  = 8'h88;  // bits 6:4 and 2:0 reserved
    localparam logic [7:0]  MASK_CODING    = 8'h3F;  // bits 7:6 reserved
    localparam logic [7:0]  MASK_FULL      = 8'hFF;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int POS_SYNC_HI = 7;   localparam int POS_SYNC_LO = 2;
    localparam int POS_PREH_HI = 1;   localparam int POS_PREH_LO = 0;
    localparam int POS_LEN_WIDTH = 7; localparam int POS_ADDR_INC = 3;
    localparam int POS_FMT_HI  = 7;   localparam int POS_FMT_LO  = 6;
    localparam int POS_RXP_HI  = 5;   localparam int POS_RXP_LO  = 4;
    localparam int POS_SYMMAP  = 3;   localparam int POS_BITORD  = 2;
    localparam int POS_PPAT_HI = 1;   localparam int POS_PPAT_LO = 0;
    localparam int POS_HDRCHK  = 5;   localparam int POS_FEC_STOP = 4;
    localparam int POS_INT_START = 3; localparam int POS_3OF6    = 2;
    localparam int POS_BIPHASE = 1;   localparam int POS_LENMODE = 0;
    localparam int POS_CRC_HI  = 7;   localparam int POS_CRC_LO  = 5;
    localparam int POS_STAT_ACT = 0;  localparam int POS_STAT_PEND = 1;

    // ------------------------------------------------------------------
    // encodings and crc table
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_BASIC = 2'd0, FMT_G4 = 2'd1, FMT_UART = 2'd2, FMT_STACK = 2'd3
    } frame_fmt_t;
    localparam logic [31:0] POLY_NONE = 32'h0000_0000;
    localparam logic [31:0] POLY_1    = 32'h0000_0007;
    localparam logic [31:0] POLY_2    = 32'h0000_8005;
    localparam logic [31:0] POLY_3    = 32'h0000_1021;
    localparam logic [31:0] POLY_4    = 32'h0086_4CBF;
    localparam logic [31:0] POLY_5    = 32'h4C01_1BB7;  // leading zero of 0x04C011BB7 dropped
    localparam logic [5:0]  CRCW_0 = 6'd0;  localparam logic [5:0] CRCW_8  = 6'd8;
    localparam logic [5:0]  CRCW_16 = 6'd16; localparam logic [5:0] CRCW_24 = 6'd24;
    localparam logic [5:0]  CRCW_32 = 6'd32;

    // decoded configuration handed to the framer
    typedef struct packed {
        logic [5:0]  syncLenBits;     // sync field length in bits
        logic [9:0]  preamblePairs;   // preamble bit pair count
        logic        lenTwoBytes;     // length field is two bytes
        logic        addrInclude;     // address field present
        frame_fmt_t  frameFormat;     // frame family
        logic [1:0]  rxPath;          // receive data route
        logic        symMapAlt;       // alternate 4-level mapping
        logic        lsbFirst;        // bit order select
        logic [1:0]  preamblePattern; // preamble pattern select
        logic        headerCheck;     // fcs type bit, 802.15.4g only
        logic        fecRecursive;    // fec code, 802.15.4g only
        logic        interleave;      // interleaving, 802.15.4g only
        logic        stopValue;       // uart stop bit level
        logic        startValue;      // uart start bit level
        logic        threeOfSix;      // 3-of-6 line code
        logic        biphase;         // manchester coding
        logic        lengthVariable;  // variable length mode
        logic [2:0]  crcSel;          // raw crc selector
        logic [5:0]  crcWidth;        // crc width, zero for none
        logic [31:0] crcPoly;         // crc polynomial
    } cfg_t;

endpackage : pkt_fmt_pkg

/* File: verification/packet_format_config_asserts.sv */
// Purpose : port-level checks for the frame-format register block
// Assumes : one clock, asynchronous active-low reset
// Notes   : bound to every instance of the block
`timescale 1ns/10ps
module packet_format_config_asserts
    import pkt_fmt_pkg::*;
(
    input wire logic        mclk,       // system clock
    input wire logic        rstn,       // async reset, active low
    input wire logic        opStart,    // operation begins
    input wire logic        opDone,     // operation ends
    input wire logic [31:0] hrdata,     // read data
    input wire cfg_t        frameCfg,   // framer snapshot
    input wire logic        opActive    // operation in progress
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    start_opens_a: assert property (opStart |=> opActive)
        else $error("operation not active after start");
    done_closes_a: assert property (opDone && !opStart |=> !opActive)
        else $error("operation still active after done");
    snap_holds_a: assert property (!opStart |=> $stable(frameCfg))
        else $error("snapshot changed without start");
    upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    crc_byte_a: assert property (frameCfg.crcSel == 3'd1 |->
        frameCfg.crcPoly == 32'h0000_0007 && frameCfg.crcWidth == 6'd8)
        else $error("crc select one wrong");
    crc_none_a: assert property (frameCfg.crcSel == 3'd0 |-> frameCfg.crcWidth == 6'd0)
        else $error("crc select zero has width");
    crc_wide_a: assert property (frameCfg.crcSel == 3'd4 |->
        frameCfg.crcPoly == 32'h0086_4CBF && frameCfg.crcWidth == 6'd24)
        else $error("crc select four wrong");
    crc_full_a: assert property (frameCfg.crcSel == 3'd5 |->
        frameCfg.crcPoly == 32'h4C01_1BB7 && frameCfg.crcWidth == 6'd32)
        else $error("crc select five wrong");
    uart_gate_a: assert property (frameCfg.frameFormat != FMT_UART |->
        !frameCfg.stopValue && !frameCfg.startValue)
        else $error("uart bits set outside uart format");
    g4_gate_a: assert property (frameCfg.frameFormat != FMT_G4 |->
        !(frameCfg.headerCheck | frameCfg.fecRecursive | frameCfg.interleave))
        else $error("802.15.4g bits set outside that format");
endmodule : packet_format_config_asserts

bind packet_format_config packet_format_config_asserts i_chk (.mclk(mclk), .rstn(rstn),
    .opStart(opStart), .opDone(opDone), .hrdata(hrdata), .frameCfg(frameCfg),
    .opActive(opActive));

/* File: verification/tb.sv */
// Purpose : self-checking bench for the frame-format register block
// Assumes : AHB-Lite single word transfers, hready tied to hreadyout
// Notes   : scenarios run in sequence, a cycle ceiling cuts hangs
`timescale 1ns/10ps
module tb
    import pkt_fmt_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic        mclk = 0, rstn = 0, hsel = 0, hwrite = 0, opStart = 0, opDone = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0]  htrans = 0;
    wire  logic [31:0] hrdata;
    wire  logic        hreadyout, hresp, opActive, cfgPending;
    wire  cfg_t        frameCfg;
    int          errTotal = 0, checked = 0, cyc = 0;

    always #20 mclk = ~mclk;

    packet_format_config i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .opStart(opStart), .opDone(opDone), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .frameCfg(frameCfg), .opActive(opActive),
        .cfgPending(cfgPending));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one single transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wv);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'b00};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wv};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, rd);
        chk("response", 32'(HRESP_OKAY), 32'(hresp));
    endtask : rdChk

    // one-cycle start strobe, then let the snapshot settle
    task automatic startOp();
        @(posedge mclk);
        opStart <= 1'b1;
        @(posedge mclk);
        opStart <= 1'b0;
        #1;
    endtask : startOp

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testReset();
        logic [7:0] rst [6] = '{8'h80, 8'h10, 8'h00, 8'h20, 8'h00, 8'h2C};
        for (int i = 0; i < 6; i++) rdChk("reset value", 8'h2B + 8'(i), rst[i]);
        chk("sync length", 32'd32, 32'(frameCfg.syncLenBits));
        chk("preamble pairs", 32'd16, 32'(frameCfg.preamblePairs));
        chk("rx path", 32'd2, 32'(frameCfg.rxPath));
        chk("pending at reset", 32'd0, 32'(cfgPending));
        chk("idle at reset", 32'd0, 32'(opActive));
    endtask : testReset

    task automatic testReserved();
        xfer(1'b1, IDX_LEN_ADDR, 8'hFF);
        rdChk("len addr", IDX_LEN_ADDR, 8'h88);
        xfer(1'b1, IDX_CODING, 8'hFF);
        rdChk("coding", IDX_CODING, 8'h3F);
        xfer(1'b1, 8'h40, 8'hFF);
        rdChk("unmapped", 8'h40, 8'h00);
        startOp();
        chk("two byte len", 32'd1, 32'(frameCfg.lenTwoBytes));
        chk("addr include", 32'd1, 32'(frameCfg.addrInclude));
        chk("three of six", 32'd1, 32'(frameCfg.threeOfSix));
        chk("biphase", 32'd1, 32'(frameCfg.biphase));
        chk("var length", 32'd1, 32'(frameCfg.lengthVariable));
        xfer(1'b1, IDX_LEN_ADDR, 8'h00);
        startOp();
        chk("one byte len", 32'd0, 32'(frameCfg.lenTwoBytes));
        chk("no addr", 32'd0, 32'(frameCfg.addrInclude));
    endtask : testReserved

    task automatic testFormats();
        logic [1:0] f;
        xfer(1'b1, IDX_SYNC_PRE, 8'hFF);
        xfer(1'b1, IDX_PRE_LO, 8'h01);
        for (int i = 0; i < 4; i++) begin
            f = 2'(i);
            xfer(1'b1, IDX_FMT_RX, {f, 2'(i % 3), f[0], f[1], f});
            startOp();
            chk("format", 32'(f), 32'(frameCfg.frameFormat));
            chk("rx path", 32'(i % 3), 32'(frameCfg.rxPath));
            chk("sym map", 32'(f[0]), 32'(frameCfg.symMapAlt));
            chk("bit order", 32'(f[1]), 32'(frameCfg.lsbFirst));
            chk("pattern", 32'(f), 32'(frameCfg.preamblePattern));
            chk("header chk", 32'(f == 2'd1), 32'(frameCfg.headerCheck));
            chk("fec", 32'(f == 2'd1), 32'(frameCfg.fecRecursive));
            chk("stop", 32'(f == 2'd2), 32'(frameCfg.stopValue));
            chk("start", 32'(f == 2'd2), 32'(frameCfg.startValue));
            chk("interleave", 32'(f == 2'd1), 32'(frameCfg.interleave));
        end
        chk("sync length", 32'd63, 32'(frameCfg.syncLenBits));
        chk("preamble pairs", 32'h0000_0301, 32'(frameCfg.preamblePairs));
    endtask : testFormats

    task automatic testCrc();
        logic [31:0] poly [8] = '{32'h0, 32'h7, 32'h8005, 32'h1021, 32'h0086_4CBF,
                                  32'h4C01_1BB7, 32'h0, 32'h0};
        logic [5:0]  wid [8] = '{6'd0, 6'd8, 6'd16, 6'd16, 6'd24, 6'd32, 6'd0, 6'd0};
        for (int s = 0; s < 8; s++) begin
            xfer(1'b1, IDX_CRC, {3'(s), 5'h0C});
            rdChk("crc reg", IDX_CRC, {3'(s), 5'h0C});
            startOp();
            chk("crc poly", poly[s], frameCfg.crcPoly);
            chk("crc width", 32'(wid[s]), 32'(frameCfg.crcWidth));
        end
    endtask : testCrc

    task automatic testSnapshot();
        startOp();
        chk("active", 32'd1, 32'(opActive));
        xfer(1'b1, IDX_SYNC_PRE, 8'h08);
        repeat (2) @(posedge mclk);
        #1;
        chk("held sync", 32'd63, 32'(frameCfg.syncLenBits));
        chk("pending", 32'd1, 32'(cfgPending));
        rdChk("status", IDX_STATUS, 8'h03);
        @(posedge mclk);
        opDone <= 1'b1;
        @(posedge mclk);
        opDone <= 1'b0;
        #1;
        chk("idle", 32'd0, 32'(opActive));
        chk("idle sync", 32'd63, 32'(frameCfg.syncLenBits));
        startOp();
        chk("new sync", 32'd2, 32'(frameCfg.syncLenBits));
    endtask : testSnapshot

    // ----------------------------------------------------------------
    // verdict, timeout and main sequence
    // ----------------------------------------------------------------
    task automatic finishTest();
        $display("errors %0d checks %0d", errTotal, checked);
        if (errTotal == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finishTest

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errTotal++;
            finishTest();
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        testReset();
        testReserved();
        testFormats();
        testCrc();
        testSnapshot();
        finishTest();
    end
endmodule : tb
